// ---- logic/filler_octet_insert.sv ----
/*
 * Dummy-cell insertion control of the unstructured reassembly path, with
 * its APB register file and one late-cell timer per port.
 * Assumes cell-stream inputs are synchronous to pclk and that the circular
 * buffer writer accepts one octet per cycle while buf_wr_ready is high.
 */
// Added by the designer: the APB slave port.
`default_nettype none

`include "udt_regs.svh"

// What this block does
// - Control register low byte holds the programmable filler octet for dummy cells.
// - Each dummy cell writes the filler octet 47 times into the port buffer.
// - Filler octet resets to FF (silence); control register resets to 00FF.
// - With bit 8 set, insert one dummy cell per lost cell, up to seven.
// - With bit 8 clear, at most two dummy cells per multi-cell loss.
// - With bit 9 set, a late in-sync port gets one dummy cell.
// - Each port's late timeout comes from its own timeout register.
// - Control register bits 15 to 10 read as zero.
module filler_octet_insert
    import udt_pkg::*;
#(
    parameter int NPORTS = 28,
    parameter int TW     = 16
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                ce,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [15:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                loss_valid,
    input  wire udt_pkg::udt_loss_t  loss,
    output logic                     loss_ready,
    input  wire logic                cell_arrive,
    input  wire logic [UDT_PW-1:0]   cell_port,
    input  wire logic [NPORTS-1:0]   port_in_sync,
    output logic                     buf_wr_valid,
    output udt_pkg::udt_buf_wr_t     buf_wr,
    input  wire logic                buf_wr_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    import udt_pkg::*;

    localparam logic [15:0] CTRL_ADDR = 16'(`UDT_CTRL_IDX * 4);
    localparam logic [15:0] STAT_ADDR = 16'(`UDT_STAT_IDX * 4);
    localparam logic [15:0] TMO_ADDR  = 16'(`UDT_TMO_BASE_IDX * 4);
    localparam int          TMO_SHIFT = $clog2(`UDT_TMO_STEP_IDX * 4);
    localparam logic [15:0] TICK_LAST = 16'(`UDT_TICK_CYCLES - 1);

    typedef struct packed {
        logic                     pready;
        logic                     pslverr;
        logic [31:0]              prdata;
        logic [7:0]               filler;
        logic                     ins_lost;
        logic                     late_en;
        logic [NPORTS-1:0][TW-1:0] tmo;
        udt_state_t               st;
        logic [UDT_PW-1:0]        cur_port;
        logic [7:0]               cur_fill;
        logic [2:0]               cells;
        logic [5:0]               octs;
        logic                     wr_valid;
        logic                     loss_ready;
        logic [NPORTS-1:0]        late_ack;
        logic [15:0]              tick_cnt;
        logic                     tick;
        logic [15:0]              ins_count;
    } udt_state_reg_t;

    udt_state_reg_t    s;
    udt_state_reg_t    n;
    logic [NPORTS-1:0] expired;
    logic [15:0]       tmo_off;
    logic [UDT_PW-1:0] tmo_idx;
    logic              hit_ctrl;
    logic              hit_stat;
    logic              hit_tmo;
    logic [7:0]        want;
    logic              late_found;
    logic [UDT_PW-1:0] late_port;

    assign tmo_off  = paddr - TMO_ADDR;
    assign tmo_idx  = tmo_off[TMO_SHIFT +: UDT_PW];
    assign hit_ctrl = (paddr == CTRL_ADDR);
    assign hit_stat = (paddr == STAT_ADDR);
    assign hit_tmo  = (paddr >= TMO_ADDR) && (tmo_off[TMO_SHIFT-1:0] == '0)
                      && (32'(tmo_off >> TMO_SHIFT) < NPORTS);

    genvar gi;
    generate
        for (gi = 0; gi < NPORTS; gi++) begin : g_tmr
            udt_late_timer #(
                .TW(TW)
            ) u_tmr (
                .pclk    (pclk),
                .presetn (presetn),
                .ce      (ce),
                .run     (s.late_en && port_in_sync[gi]),
                .restart (cell_arrive && cell_port == UDT_PW'(gi)),
                .tick    (s.tick),
                .timeout (s.tmo[gi]),
                .ack     (s.late_ack[gi]),
                .expired (expired[gi])
            );
        end
    endgenerate

    // Lowest-numbered late port wins; fairness is not needed because each
    // service is short compared with any useful timeout.
    always_comb begin
        late_found = 1'b0;
        late_port  = '0;
        for (int i = NPORTS - 1; i >= 0; i--) begin
            if (expired[i]) begin
                late_found = 1'b1;
                late_port  = UDT_PW'(i);
            end
        end
    end

    always_comb begin
        n          = s;
        n.pready   = 1'b0;
        n.pslverr  = 1'b0;
        n.late_ack = '0;
        n.tick     = 1'b0;
        want       = 8'h00;

        if (s.tick_cnt == TICK_LAST) begin
            n.tick_cnt = 16'h0000;
            n.tick     = 1'b1;
        end else begin
            n.tick_cnt = s.tick_cnt + 16'h0001;
        end

        // One wait state: the answer is prepared in the first access cycle.
        if (psel && penable && !s.pready) begin
            n.pready  = 1'b1;
            n.pslverr = !(hit_ctrl || hit_stat || hit_tmo);
            n.prdata  = 32'h0000_0000;
            if (hit_ctrl) begin
                n.prdata = {22'h0, s.late_en, s.ins_lost, s.filler};
            end else if (hit_stat) begin
                n.prdata = {s.ins_count, 7'h00, s.cells, s.cur_port, s.st == UDT_FILL};
            end else if (hit_tmo) begin
                n.prdata = 32'(s.tmo[tmo_idx]);
            end
        end
        if (psel && penable && s.pready && pwrite) begin
            if (hit_ctrl) begin
                n.filler   = pwdata[`UDT_FILL_MSB:0];
                n.ins_lost = pwdata[`UDT_INS_LOST_BIT];
                n.late_en  = pwdata[`UDT_LATE_BIT];
            end else if (hit_tmo) begin
                n.tmo[tmo_idx] = pwdata[TW-1:0];
            end
        end

        case (s.st)
            UDT_IDLE: begin
                if (loss_valid && s.loss_ready) begin
                    if (s.ins_lost) begin
                        want = (loss.count > `UDT_MAX_LOST) ? `UDT_MAX_LOST
                                                             : loss.count;
                    end else begin
                        want = (loss.count > `UDT_MAX_DEFAULT) ? `UDT_MAX_DEFAULT
                                                                : loss.count;
                    end
                    n.cur_port = loss.port;
                end else if (s.late_en && late_found) begin
                    want                  = 8'h01;
                    n.cur_port            = late_port;
                    n.late_ack[late_port] = 1'b1;
                end
                if (want != 8'h00) begin
                    // The control fields are sampled only here, at the decision.
                    n.cur_fill = s.filler;
                    n.cells    = want[2:0];
                    n.octs     = 6'd0;
                    n.wr_valid = 1'b1;
                    n.st       = UDT_FILL;
                end
            end
            UDT_FILL: begin
                if (s.wr_valid && buf_wr_ready) begin
                    if (s.octs == `UDT_CELL_OCTETS - 6'd1) begin
                        n.octs      = 6'd0;
                        n.ins_count = s.ins_count + 16'h0001;
                        n.cells     = s.cells - 3'd1;
                        if (s.cells == 3'd1) begin
                            n.wr_valid = 1'b0;
                            n.st       = UDT_IDLE;
                        end
                    end else begin
                        n.octs = s.octs + 6'd1;
                    end
                end
            end
            default: begin
                n.st       = UDT_IDLE;
                n.wr_valid = 1'b0;
            end
        endcase

        n.loss_ready = (n.st == UDT_IDLE) && !(loss_valid && s.loss_ready);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s        <= '0;
            s.filler <= `UDT_FILL_RST;
        end else if (ce) begin
            s <= n;
        end
    end

    assign prdata       = s.prdata;
    assign pready       = s.pready;
    assign pslverr      = s.pslverr;
    assign loss_ready   = s.loss_ready;
    assign buf_wr_valid = s.wr_valid;
    assign buf_wr.port  = s.cur_port;
    assign buf_wr.data  = s.cur_fill;

endmodule

`default_nettype wire

// ---- logic/udt_regs.svh ----
/*
 * Register map, field positions, reset values and timing counts of the
 * unstructured reassembly dummy-cell insertion block.
 * Assumes a 32-bit APB bus where each register index maps to byte index*4.
 */
`ifndef UDT_REGS_SVH
`define UDT_REGS_SVH

`define UDT_CTRL_IDX        16'h2000
`define UDT_STAT_IDX        16'h2001
`define UDT_TMO_BASE_IDX    16'h3200
`define UDT_TMO_STEP_IDX    2

`define UDT_CTRL_RST        16'h00FF
`define UDT_FILL_RST        8'hFF
`define UDT_FILL_MSB        7
`define UDT_INS_LOST_BIT    8
`define UDT_LATE_BIT        9

`define UDT_CELL_OCTETS     6'd47
`define UDT_MAX_LOST        8'd7
`define UDT_MAX_DEFAULT     8'd2

`define UDT_CLK_NS          10
`define UDT_TICK_NS         1000
`define UDT_TICK_CYCLES     ((`UDT_TICK_NS + `UDT_CLK_NS - 1) / `UDT_CLK_NS)

`endif

// ---- logic/udt_pkg.sv ----
/*
 * Types shared by the dummy-cell insertion block.
 * Assumes at most 32 ports, so a port number fits in five bits.
 */
`default_nettype none

package udt_pkg;

    timeunit 1ns;
    timeprecision 1ps;

    localparam int UDT_PW = 5;

    typedef enum logic {
        UDT_IDLE,
        UDT_FILL
    } udt_state_t;

    typedef struct packed {
        logic [UDT_PW-1:0] port;
        logic [7:0]        count;
    } udt_loss_t;

    typedef struct packed {
        logic [UDT_PW-1:0] port;
        logic [7:0]        data;
    } udt_buf_wr_t;

endpackage

`default_nettype wire

// ---- logic/udt_late_timer.sv ----
/*
 * Late-cell timer of one port: counts ticks since the last cell and raises
 * a sticky expiry flag when the port's timeout passes.
 * Assumes tick is a one-cycle pulse from the parent's prescaler.
 */
`default_nettype none

module udt_late_timer #(
    parameter int TW = 16
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          ce,
    input  wire logic          run,
    input  wire logic          restart,
    input  wire logic          tick,
    input  wire logic [TW-1:0] timeout,
    input  wire logic          ack,
    output logic               expired
);
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [TW-1:0] cnt;
        logic          exp;
    } udt_tmr_t;

    udt_tmr_t s;
    udt_tmr_t n;
    logic     set_exp;

    always_comb begin
        n       = s;
        set_exp = 1'b0;
        if (restart || !run) begin
            n.cnt = '0;
        end else if (tick && timeout != '0) begin
            if (s.cnt + TW'(1) >= timeout) begin
                set_exp = 1'b1;
                n.cnt   = '0;
            end else begin
                n.cnt = s.cnt + TW'(1);
            end
        end
        // An expiry in the same cycle as the acknowledge is kept pending.
        if (set_exp) begin
            n.exp = 1'b1;
        end else if (ack || !run) begin
            n.exp = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else if (ce) begin
            s <= n;
        end
    end

    assign expired = s.exp;

endmodule

`default_nettype wire

// ---- tb/udt_di_asserts.sv ----
/* Port checker of the dummy-cell insertion block.
   Assumes it is bound to the block and that ce stays high. */
`default_nettype none
module udt_di_asserts
    import udt_pkg::*;
#(parameter int NPORTS = 28, parameter int TW = 16) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              ce,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [15:0]       paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              loss_valid,
    input wire udt_loss_t         loss,
    input wire logic              loss_ready,
    input wire logic              cell_arrive,
    input wire logic [UDT_PW-1:0] cell_port,
    input wire logic [NPORTS-1:0] port_in_sync,
    input wire logic              buf_wr_valid,
    input wire udt_buf_wr_t       buf_wr,
    input wire logic              buf_wr_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] ctl_ff;
    logic [7:0] fil_ff;
    logic [8:0] oct_ff;
    logic [3:0] exp_ff;
    logic [7:0] cap;
    assign cap = ctl_ff[8] ? 8'h07 : 8'h02;
    // Shadows are taken only while idle, so a write during a burst must not move them.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_ff <= 10'h0FF;
            fil_ff <= 8'hFF;
            oct_ff <= 9'h000;
            exp_ff <= 4'h0;
        end else begin
            if (psel && penable && pready && pwrite && !pslverr && paddr == 16'h8000) begin
                ctl_ff <= pwdata[9:0];
            end
            oct_ff <= loss_ready ? 9'h000 : oct_ff + 9'(buf_wr_valid && buf_wr_ready);
            if (loss_ready) begin
                fil_ff <= ctl_ff[7:0];
                exp_ff <= !loss_valid ? 4'h1 : (loss.count > cap) ? cap[3:0] : loss.count[3:0];
            end
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup; psel && !penable; endsequence
    sequence s_access; psel && penable; endsequence
    sequence s_take; loss_valid && loss_ready; endsequence
    property p_apb_wait; s_setup ##1 s_access |=> pready ##1 !pready; endproperty
    property p_ctl_low; pready && !pwrite && !pslverr && paddr == 16'h8000 |-> prdata[9:0] == ctl_ff; endproperty
    property p_ro_zero; pready && !pslverr && paddr == 16'h8000 |-> prdata[31:10] == 22'h0; endproperty
    property p_unmapped; pready && paddr[15:12] == 4'h0 |-> pslverr && prdata == 32'h0; endproperty
    property p_fill; buf_wr_valid |-> buf_wr.data == fil_ff; endproperty
    property p_hold; buf_wr_valid && !buf_wr_ready |=> buf_wr_valid && $stable(buf_wr); endproperty
    property p_cells; $fell(buf_wr_valid) |-> oct_ff == 9'h02F * exp_ff; endproperty
    property p_accept; s_take ##0 loss.count != 8'h00 |=> !loss_ready && buf_wr_valid; endproperty
    // A taken event always drops ready, for exactly one cycle when nothing is inserted.
    property p_zero; s_take ##0 loss.count == 8'h00 |=> !loss_ready && !buf_wr_valid
        ##1 (loss_ready || buf_wr_valid); endproperty
    property p_late; $rose(buf_wr_valid) && !$past(ctl_ff[9])
        |-> $past(loss_valid && loss_ready); endproperty
    a_apb_wait: assert property (p_apb_wait) else $error("pready not a single pulse");
    a_ctl_low: assert property (p_ctl_low) else $error("control readback wrong");
    a_ro_zero: assert property (p_ro_zero) else $error("upper control bits set");
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    a_fill: assert property (p_fill) else $error("octet differs from filler");
    a_hold: assert property (p_hold) else $error("octet changed while stalled");
    a_cells: assert property (p_cells) else $error("wrong octet count in burst");
    a_accept: assert property (p_accept) else $error("loss not answered");
    a_zero: assert property (p_zero) else $error("zero loss inserted cells");
    a_late: assert property (p_late) else $error("late cell with check off");
endmodule
`default_nettype wire

// ---- tb/udt_di_cell_src.sv ----
/* Model of the incoming cell stream: offers one loss event per go pulse.
   Assumes go is a one-cycle pulse from the bench. */
`default_nettype none
module udt_di_cell_src
    import udt_pkg::*;
(
    input wire logic         pclk,
    input wire logic         presetn,
    input wire logic         go,
    input wire udt_loss_t    ev,
    input wire logic         loss_ready,
    output logic             loss_valid,
    output udt_loss_t        loss,
    output logic             cell_arrive,
    output logic [UDT_PW-1:0] cell_port
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle fields toggle every cycle so nothing can lean on a stale event.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loss_valid <= 1'b0;
            loss <= '0;
            cell_arrive <= 1'b0;
            cell_port <= '0;
        end else begin
            cell_arrive <= go;
            cell_port <= go ? ev.port : ~cell_port;
            if (go) begin
                loss_valid <= 1'b1;
                loss <= ev;
            end else if (!loss_valid || loss_ready) begin
                loss_valid <= 1'b0;
                loss <= ~loss;
            end
        end
    end
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
/* Self-checking bench of the dummy-cell insertion block.
   Assumes the checker and the cell-stream model are compiled first. */
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import udt_pkg::*;
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, er, go;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic loss_valid, loss_ready, cell_arrive, buf_wr_valid, buf_wr_ready;
    udt_loss_t loss, ev;
    udt_buf_wr_t buf_wr;
    logic [UDT_PW-1:0] cell_port;
    logic [27:0] port_in_sync;
    logic [7:0] fill;
    logic [7:0] cnts [8];
    int err_total = 0, cmp_count = 0, oct_n = 0, cyc = 0, seed = 30;
    int oct0 = 0, cell_exp = 0;
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
    $display("[FAIL] %0t got %0h want %0h", $time, a, b); end end
    filler_octet_insert dut (.*);
    udt_di_cell_src src (.pclk, .presetn, .go, .ev, .loss_ready, .loss_valid, .loss,
                         .cell_arrive, .cell_port);
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // The buffer side stalls at random, a quarter of all cycles.
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        buf_wr_ready <= ($random(seed) & 3) != 0;
        if (buf_wr_valid === 1'b1 && buf_wr_ready === 1'b1) begin
            oct_n <= oct_n + 1;
            `CHK(buf_wr.data, fill)
        end
        if (cyc == 60000) begin
            err_total++;
            give_verdict();
        end
    end
    task give_verdict();
        $display("errors %0d compares %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [8:0] exp_oct(input logic [7:0] n, input logic m);
        logic [7:0] cap;
        cap = m ? 8'h07 : 8'h02;
        return 9'h02F * ((n > cap) ? cap : n);
    endfunction
    task wait_idle();
        do @(posedge pclk); while (loss_ready !== 1'b1 || buf_wr_valid !== 1'b0);
    endtask
    // A write lands mid-burst on purpose; the running burst must ignore it.
    task run_loss(input logic [7:0] n, input logic m);
        fill = 8'($random(seed));
        apb(1'b1, 16'h8000, {22'h0, 1'b0, m, fill});
        oct0 = oct_n;
        ev.port = 5'({$random(seed)} % 28);
        ev.count = n;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        do @(posedge pclk); while (!(loss_valid === 1'b1 && loss_ready === 1'b1));
        apb(1'b1, 16'h8000, {24'h0, ~fill});
        wait_idle();
        `CHK(oct_n - oct0, exp_oct(n, m))
        cell_exp += exp_oct(n, m) / 47;
    endtask
    initial begin
        {ce, psel, penable, pwrite, go, presetn} = 6'h20;
        paddr = 16'h0000;
        pwdata = 32'h0;
        ev = '0;
        port_in_sync = '0;
        fill = 8'hFF;
        cnts = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h07, 8'h08, 8'hFF, 8'h05};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 16'h8000, 32'h0);
        `CHK(rd, 32'h000000FF)
        apb(1'b1, 16'h8000, 32'hFFFFFFFF);
        apb(1'b0, 16'h8000, 32'h0);
        `CHK(rd, 32'h000003FF)
        apb(1'b1, 16'h0010, 32'h1);
        `CHK(er, 1'b1)
        for (int m = 0; m < 2; m++) begin
            for (int i = 0; i < 8; i++) begin
                run_loss(i == 7 ? 8'($random(seed)) : cnts[i], 1'(m));
            end
        end
        apb(1'b1, 16'hC818, 32'h1);
        fill = 8'h5A;
        apb(1'b1, 16'h8000, 32'h0000025A);
        oct0 = oct_n;
        port_in_sync <= 28'h0000008;
        do @(posedge pclk); while (buf_wr_valid !== 1'b1);
        port_in_sync <= '0;
        `CHK(buf_wr.port, 5'h03)
        wait_idle();
        `CHK(oct_n - oct0, 47)
        // Status: inserted-cell total above, idle with port 3 as last port below.
        apb(1'b0, 16'h8004, 32'h0);
        `CHK(rd[31:16], 16'(cell_exp + 1))
        `CHK(rd[15:0], 16'h0006)
        give_verdict();
    end
endmodule
bind filler_octet_insert udt_di_asserts #(.NPORTS(NPORTS), .TW(TW)) u_chk (.*);
`default_nettype wire
